// ---- design/ttc_cfg.svh ----
// Constants for the temperature trip comparator block
// Functional notes
// - The under-window flag (bit 13) sets below lower limit minus hysteresis and clears at the lower limit; the over-window flag (bit 14) sets above the upper limit and clears at upper limit minus hysteresis.
// - The over-critical flag (bit 15) sets when temperature reaches the critical threshold and clears only below critical minus hysteresis.
// - Temperature is reported as an 11-bit two's-complement value with 0.125 degC per step.
// - Bit 0 of the temperature word reads zero and bit 11 weighs 128 degC.
// - The top three bits of the temperature word give trip status from the current temperature, independent of the alert output.
// - Bit 12 is the sign, zero positive and one negative, with the field in two's complement.
// - Each trip-point register holds its limit in bits 12 to 2 in two's complement, bit 2 weighing 0.25 degC.
// - Bits 15 to 13 and 1 to 0 of each trip-point register are read-only zero.
// - A read/write upper-limit register sits at pointer 02h and resets to zero.
// - A read/write lower-limit register sits at pointer 03h and resets to zero.
// - A read/write critical-limit register sits at pointer 04h and resets to zero.
// - Flag evaluation always uses the limits currently held, so a new limit acts on the next comparison.
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH
`define TTC_PTR_UPPER     8'h02
`define TTC_PTR_LOWER     8'h03
`define TTC_PTR_CRIT      8'h04
`define TTC_PTR_TEMP      8'h05
`define TTC_LIMIT_RESET   16'h0000
`define TTC_LIMIT_MASK    16'h1ffc
`define TTC_BIT_CRIT      15
`define TTC_BIT_OVER      14
`define TTC_BIT_UNDER     13
`define TTC_TEMP_MSB      12
`define TTC_TEMP_LSB      1
`define TTC_NUM_LIMITS    3
`endif

// ---- design/ttc_limit_regs.sv ----
// Three trip-point limit registers with masked write and all limits driven straight out on o_limits
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_limit_regs (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // Write port
  input  wire logic              i_wr_en,
  input  wire logic [7:0]        i_ptr,
  input  wire ttc_pkg::ttc_word_t i_wdata,
  // Limits
  output logic [47:0]            o_limits
);
  genvar g;
  generate
    for (g = 0; g < `TTC_NUM_LIMITS; g = g + 1)
    begin : g_lim
      wire logic hit;
      assign hit = i_wr_en && (i_ptr == (`TTC_PTR_UPPER + 8'(g)));
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          o_limits[g*16 +: 16] <= `TTC_LIMIT_RESET;
        else if (hit)
          o_limits[g*16 +: 16] <= i_wdata & `TTC_LIMIT_MASK;
      end
    end
  endgenerate
endmodule : ttc_limit_regs
`default_nettype wire

// ---- design/ttc_pkg.sv ----
// Types for the temperature trip comparator block
package ttc_pkg;
  typedef logic [15:0] ttc_word_t;
  typedef logic signed [12:0] ttc_cmp_t;
endpackage : ttc_pkg

// ---- design/ttc_trip_compare.sv ----
// Trip-point registers and hysteretic trip-status comparator
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_trip_compare (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_b,
  // Register access from the serial protocol engine
  input  wire logic               i_wr_en,
  input  wire logic               i_rd_en,
  input  wire logic [7:0]         i_ptr,
  input  wire ttc_pkg::ttc_word_t i_wdata,
  output logic [15:0]             o_rdata,
  output logic                    o_rvalid,
  // Converter result, 11-bit two's complement in 0.125 degC steps
  input  wire logic               i_conv_valid,
  input  wire logic [10:0]        i_conv_temp,
  // Hysteresis from configuration logic, in 0.125 degC steps
  input  wire logic [4:0]         i_hyst,
  // Trip status towards alert logic
  output logic                    o_over_critical_flag,
  output logic                    o_over_window_flag,
  output logic                    o_under_window_flag,
  output logic [15:0]             o_temp_word
);
  logic [47:0] limits;
  logic [10:0] temp_reg;
  logic        crit_reg;
  logic        over_reg;
  logic        under_reg;
  logic        crit_next;
  logic        over_next;
  logic        under_next;

  ttc_limit_regs u_limits (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_wr_en   (i_wr_en),
    .i_ptr     (i_ptr),
    .i_wdata   (i_wdata),
    .o_limits  (limits)
  );

  // Limits at 0.25 degC shifted left one so they share the 0.125 degC scale
  wire ttc_pkg::ttc_cmp_t upper_s;
  wire ttc_pkg::ttc_cmp_t lower_s;
  wire ttc_pkg::ttc_cmp_t crit_s;
  wire ttc_pkg::ttc_cmp_t temp_s;
  wire ttc_pkg::ttc_cmp_t hyst_s;
  assign upper_s = {limits[12], limits[12:2], 1'b0};
  assign lower_s = {limits[28], limits[28:18], 1'b0};
  assign crit_s  = {limits[44], limits[44:34], 1'b0};
  assign temp_s  = {{2{i_conv_temp[10]}}, i_conv_temp};
  assign hyst_s  = {8'h00, i_hyst};

  // Hysteresis held in the flag itself: set and clear points differ
  always_comb
  begin
    crit_next  = crit_reg ? (temp_s >= (crit_s - hyst_s)) : (temp_s >= crit_s);
    over_next  = over_reg ? (temp_s > (upper_s - hyst_s)) : (temp_s > upper_s);
    under_next = under_reg ? (temp_s < lower_s) : (temp_s < (lower_s - hyst_s));
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      temp_reg  <= 11'h000;
      crit_reg  <= 1'b0;
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end
    else if (i_conv_valid)
    begin
      temp_reg  <= i_conv_temp;
      crit_reg  <= crit_next;
      over_reg  <= over_next;
      under_reg <= under_next;
    end
  end

  // Status comes only from comparison, never from the alert pin state
  wire ttc_pkg::ttc_word_t temp_word;
  // The 11-bit value is sign-extended once, so bit 11 repeats the sign at bit 12
  assign temp_word = {crit_reg, over_reg, under_reg, temp_reg[10], temp_reg[10:0], 1'b0};

  wire logic [15:0] rd_mux;
  assign rd_mux = (i_ptr == `TTC_PTR_UPPER) ? limits[15:0]  :
                  (i_ptr == `TTC_PTR_LOWER) ? limits[31:16] :
                  (i_ptr == `TTC_PTR_CRIT)  ? limits[47:32] :
                  (i_ptr == `TTC_PTR_TEMP)  ? temp_word     : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata              <= 16'h0000;
      o_rvalid             <= 1'b0;
      o_over_critical_flag <= 1'b0;
      o_over_window_flag   <= 1'b0;
      o_under_window_flag  <= 1'b0;
      o_temp_word          <= 16'h0000;
    end
    else
    begin
      o_rdata              <= i_rd_en ? rd_mux : o_rdata;
      o_rvalid             <= i_rd_en;
      o_over_critical_flag <= crit_reg;
      o_over_window_flag   <= over_reg;
      o_under_window_flag  <= under_reg;
      o_temp_word          <= temp_word;
    end
  end
endmodule : ttc_trip_compare
`default_nettype wire

// ---- verification/tb_temp_trip_compare_regs.sv ----
// Self-checking bench for the trip comparator
`timescale 1ns/1ps
`default_nettype none
module tb_temp_trip_compare_regs;
  logic        clk, rst_b, wr, rd, cv, rv, fc, fo, fu;
  logic [7:0]  ptr;
  logic [10:0] ct;
  logic [15:0] wd, rdat, tw, got;
  int          failures, checks_done, i;
  // Temperatures in 0.125 degC steps, walking every set and clear threshold
  logic [10:0] tt [19] = '{11'h0a0, 11'h0c8, 11'h0c9, 11'h0c1, 11'h0c0, 11'h140, 11'h138,
                           11'h137, 11'h04f, 11'h047, 11'h04f, 11'h050, 11'h0c9, 11'h0c8,
                           11'h0c9, 11'h0aa, 11'h0a9, 11'h732, 11'h732};
  logic [2:0]  ef [19] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h6, 3'h6, 3'h2, 3'h0, 3'h1, 3'h1,
                           3'h0, 3'h2, 3'h0, 3'h2, 3'h2, 3'h0, 3'h1, 3'h0};
  // Hysteresis per step: nominal, then none, then the largest amount, then nominal
  logic [4:0]  hh [19] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08,
                           5'h08, 5'h08, 5'h08, 5'h00, 5'h00, 5'h1f, 5'h1f, 5'h1f, 5'h08,
                           5'h08};
  logic [4:0]  hy;
  ttc_host_model host (.i_sys_clk(clk), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd),
    .o_ptr(ptr), .o_wdata(wd));
  ttc_trip_compare dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_wr_en(wr), .i_rd_en(rd),
    .i_ptr(ptr), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .i_conv_valid(cv),
    .i_conv_temp(ct), .i_hyst(hy), .o_over_critical_flag(fc), .o_over_window_flag(fo),
    .o_under_window_flag(fu), .o_temp_word(tw));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Waits past both output stages so either pipeline depth is settled
  task automatic conv(input logic [10:0] t);
    @(negedge clk);
    {cv, ct} = {1'b1, t};
    @(negedge clk);
    cv = 1'b0;
    repeat (3) @(negedge clk);
  endtask : conv
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #5000;
    failures++;
    end_of_test;
  end
  initial
  begin
    {rst_b, cv, ct, hy} = '0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    for (i = 2; i < 5; i++)
    begin
      host.rd(8'(i), got);
      chk(got, 16'h0000);
      host.wr(8'(i), 16'hffff);
      host.rd(8'(i), got);
      chk(got, 16'h1ffc);
    end
    host.wr(8'h07, 16'h1234);
    host.rd(8'h07, got);
    chk(got, 16'h0000);
    host.wr(8'h02, 16'h0190);
    host.wr(8'h03, 16'h00a0);
    host.wr(8'h04, 16'h0280);
    for (i = 0; i < 19; i++)
    begin
      if (i == 18) host.wr(8'h03, 16'h1e20);
      hy = hh[i];
      conv(tt[i]);
      chk(tw, {ef[i], tt[i][10], tt[i], 1'b0});
      chk({13'h0000, fc, fo, fu}, {13'h0000, ef[i]});
    end
    host.wr(8'h05, 16'hffff);
    host.rd(8'h05, got);
    chk(got, 16'h1e64);
    // Mid-run reset with flags up must clear limits and status alike
    conv(11'h140);
    chk(tw, 16'hc280);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk({13'h0000, fc, fo, fu}, 16'h0000);
    chk(tw, 16'h0000);
    for (i = 2; i < 5; i++)
    begin
      host.rd(8'(i), got);
      chk(got, 16'h0000);
    end
    end_of_test;
  end
endmodule : tb_temp_trip_compare_regs
`default_nettype wire

// ---- verification/ttc_host_model.sv ----
// Host model issuing whole-word register writes and reads
`timescale 1ns/1ps
`default_nettype none
module ttc_host_model (
  // Bus side
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [7:0]       o_ptr,
  output logic [15:0]      o_wdata
);
  initial {o_wr_en, o_rd_en, o_ptr, o_wdata} = '0;
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(negedge i_sys_clk);
    {o_wr_en, o_ptr, o_wdata} = {1'b1, p, d};
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    @(negedge i_sys_clk);
    {o_rd_en, o_ptr} = {1'b1, p};
    @(negedge i_sys_clk);
    o_rd_en = 1'b0;
    d = i_rdata;
  endtask : rd
endmodule : ttc_host_model
`default_nettype wire

// ---- verification/ttc_trip_compare_asserts.sv ----
// Port assertions for the trip comparator
`timescale 1ns/1ps
`default_nettype none
module ttc_trip_compare_asserts (
  // Watched ports
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_rd_en,
  input wire logic [7:0]  i_ptr,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_conv_valid,
  input wire logic [10:0] i_conv_temp,
  input wire logic        o_over_critical_flag,
  input wire logic        o_over_window_flag,
  input wire logic        o_under_window_flag,
  input wire logic [15:0] o_temp_word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  rvalid_pulse_a: assert property (o_rvalid == $past(i_rd_en)) else $error("rvalid");
  rdata_hold_a: assert property (!i_rd_en |=> $stable(o_rdata)) else $error("rdata");
  rsv_bits_a: assert property (o_rvalid && $past(i_ptr) != 8'h05 |->
    o_rdata[15:13] == 3'h0 && o_rdata[1:0] == 2'h0) else $error("reserved");
  temp_lsb_a: assert property (o_temp_word[0] == 1'b0) else $error("lsb");
  sign_bit_a: assert property (o_temp_word[12] == o_temp_word[11]) else $error("sign");
  status_bits_a: assert property (o_temp_word[15:13] == {o_over_critical_flag,
    o_over_window_flag, o_under_window_flag}) else $error("status");
  temp_field_a: assert property ($past(i_conv_valid, 2) |->
    o_temp_word[11:1] == $past(i_conv_temp, 2)) else $error("temp");
  word_hold_a: assert property (!$past(i_conv_valid, 2) && !$past(i_conv_valid, 3) |->
    $stable(o_temp_word)) else $error("hold");
endmodule : ttc_trip_compare_asserts
bind ttc_trip_compare ttc_trip_compare_asserts u_chk (.*);
`default_nettype wire
